// [core/csrf_regs.vh]
// Purpose: Register numbers, field positions and reset values of the CPU system register file.
// Assumes: Included by the register file; its storage module does not include it.
// Notes: Register numbers are those used by the load and store system register instructions.
`ifndef CSRF_REGS_VH
`define CSRF_REGS_VH

// ==========================================================================
// Register numbers
`define CSRF_NUM_W 5
`define CSRF_NUM_MSAVE_PC 5'h00
`define CSRF_NUM_MSAVE_ST 5'h01
`define CSRF_NUM_NSAVE_PC 5'h02
`define CSRF_NUM_NSAVE_ST 5'h03
`define CSRF_NUM_CAUSE 5'h04
`define CSRF_NUM_PSW 5'h05
`define CSRF_NUM_TC_PC 5'h10
`define CSRF_NUM_TC_ST 5'h11
`define CSRF_NUM_TRAP_PC 5'h12
`define CSRF_NUM_TRAP_ST 5'h13
`define CSRF_NUM_TC_BASE 5'h14
`define CSRF_NUM_DEBUG 5'h15

// ==========================================================================
// Field layout
`define CSRF_PC_MSB 25
`define CSRF_ST_MSB 7
`define CSRF_ID_BIT 5
`define CSRF_PC_PAD 6'h00
`define CSRF_ST_PAD 24'h000000
`define CSRF_STORE_SEL_MSB 1

// ==========================================================================
// Reset values
`define CSRF_RST_WORD 32'h00000000
`define CSRF_RST_PSW 8'h20
`define CSRF_RST_PC 26'h0000000
`define CSRF_RST_ST 8'h00

`endif

// [core/csrf_store.v]
// Purpose: Small storage for the four table call and trap save registers.
// Assumes: One write port, one read port, read data registered.
// Notes: Full 32-bit words, no fixed bits.
`timescale 1ns/10ps
module csrf_store
#(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW = 2
)
(
	input wire sys_clk,
	input wire rst,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
integer i;

// ==========================================================================
// Storage and registered read
// Reset clears the words so reads are never unknown.
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		for (i = 0; i < DEPTH; i = i + 1)
			mem[i] <= {WIDTH{1'b0}};
		rd_data <= {WIDTH{1'b0}};
	end
	else
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
end

endmodule

// [core/csrf_top.v]
// Purpose: System register file of a 32-bit CPU core.
// Assumes: Driven by the execution and exception sequencing logic on sys_clk.
// Notes: Store reads return data one cycle after the request.
`timescale 1ns/10ps
`include "csrf_regs.vh"
module csrf_top
#(
	parameter CAUSE_W = 32
)
(
	// Clock and reset.
	input wire sys_clk,
	input wire rst,
	// Load system register instruction, one strobe per instruction.
	input wire ld_valid,
	input wire [4:0] ld_num,
	input wire [31:0] ld_data,
	// Store system register instruction; the answer comes one cycle later.
	input wire st_valid,
	input wire [4:0] st_num,
	output reg [31:0] st_data,
	output reg st_ready,
	// Events from the exception sequencer.
	input wire mi_take,
	input wire nmi_take,
	input wire [31:0] next_pc_in,
	input wire [31:0] psw_in,
	input wire psw_upd,
	input wire [CAUSE_W-1:0] cause_code,
	// Return path selects and the values they restore.
	input wire ret_maskable,
	input wire ret_nmi,
	input wire ret_table_call,
	output reg [31:0] ret_pc,
	output reg [31:0] ret_status,
	// Debug word and status outputs for the rest of the core.
	input wire [31:0] debug_in,
	output wire [31:0] program_status_word_out,
	output wire table_call_base_out,
	output wire [31:0] table_call_base_word,
	output wire int_block
);

// ==========================================================================
// Helpers
// Shapes a 32-bit value to the 26-bit even PC form.
function [31:0] pc_fmt;
	input [31:0] v;
	begin
		pc_fmt = {`CSRF_PC_PAD, v[`CSRF_PC_MSB:1], 1'b0};
	end
endfunction

// Keeps only the low status byte.
function [31:0] st_fmt;
	input [31:0] v;
	begin
		st_fmt = {`CSRF_ST_PAD, v[`CSRF_ST_MSB:0]};
	end
endfunction

// Tests whether a number targets the table call or trap storage.
function in_store;
	input [4:0] n;
	begin
		in_store = (n >= `CSRF_NUM_TC_PC) && (n <= `CSRF_NUM_TRAP_ST);
	end
endfunction

// Tells whether a load may change state at this number.
// Cause, debug and reserved numbers are refused here, so no later case must guard them.
function ld_writable;
	input [4:0] n;
	begin
		case (n)
		`CSRF_NUM_MSAVE_PC,
		`CSRF_NUM_MSAVE_ST,
		`CSRF_NUM_NSAVE_PC,
		`CSRF_NUM_NSAVE_ST,
		`CSRF_NUM_PSW,
		`CSRF_NUM_TC_PC,
		`CSRF_NUM_TC_ST,
		`CSRF_NUM_TRAP_PC,
		`CSRF_NUM_TRAP_ST,
		`CSRF_NUM_TC_BASE: ld_writable = 1'b1;
		`CSRF_NUM_CAUSE: ld_writable = 1'b0;
		`CSRF_NUM_DEBUG: ld_writable = 1'b0;
		default: ld_writable = 1'b0;
		endcase
	end
endfunction

// Widens a saved PC to a full word with the fixed upper bits at zero.
function [31:0] pc_word;
	input [`CSRF_PC_MSB:0] v;
	begin
		pc_word = {`CSRF_PC_PAD, v};
	end
endfunction

// Widens a saved status byte to a full word with the fixed upper bits at zero.
function [31:0] st_word;
	input [`CSRF_ST_MSB:0] v;
	begin
		st_word = {`CSRF_ST_PAD, v};
	end
endfunction

// ==========================================================================
// State
// Save PC registers keep bit 0 as written, so a read shows software's value.
reg [`CSRF_PC_MSB:0] maskable_save_pc;
reg [`CSRF_ST_MSB:0] maskable_save_status;
reg [`CSRF_PC_MSB:0] nmi_save_pc;
reg [`CSRF_ST_MSB:0] nmi_save_status;
reg [CAUSE_W-1:0] exception_cause;
reg [`CSRF_ST_MSB:0] program_status_word;
reg [31:0] table_call_base;
reg [4:0] st_num_q;
wire [31:0] store_rd;
wire ld_ok;
wire store_wr;

// Reserved numbers match nothing; loads there are dropped and stores read zero.
// Dropping them costs nothing and keeps a stray access from touching live state.
assign ld_ok = ld_valid && ld_writable(ld_num);
assign store_wr = ld_ok && in_store(ld_num);

// ==========================================================================
// Table call and trap save storage
csrf_store #(.WIDTH(32), .DEPTH(4), .AW(2)) u_store
(
	.sys_clk(sys_clk),
	.rst(rst),
	.wr_en(store_wr),
	.wr_addr(ld_num[`CSRF_STORE_SEL_MSB:0]),
	.wr_data(ld_data),
	.rd_addr(st_num[`CSRF_STORE_SEL_MSB:0]),
	.rd_data(store_rd)
);

// ==========================================================================
// Status word outputs
// The interrupt block is combinational so a load setting the flag masks at once.
assign program_status_word_out = st_fmt(st_word(program_status_word));
assign int_block = program_status_word[`CSRF_ID_BIT]
	| (ld_valid && (ld_num == `CSRF_NUM_PSW) && ld_data[`CSRF_ID_BIT]);
assign table_call_base_word = table_call_base;
assign table_call_base_out = |table_call_base;

// ==========================================================================
// Register updates
// Event saves take priority over a software load in the same cycle, so a
// handler's own load can never corrupt the context that was just saved.
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		maskable_save_pc <= `CSRF_RST_PC;
		maskable_save_status <= `CSRF_RST_ST;
		nmi_save_pc <= `CSRF_RST_PC;
		nmi_save_status <= `CSRF_RST_ST;
		exception_cause <= {CAUSE_W{1'b0}};
		table_call_base <= `CSRF_RST_WORD;
	end
	else
	begin
		// The NMI wins over a maskable event and leaves the maskable pair alone.
		if (nmi_take)
		begin
			nmi_save_pc <= next_pc_in[`CSRF_PC_MSB:0];
			nmi_save_status <= program_status_word;
			exception_cause <= cause_code;
		end
		// Software exceptions and accepted maskable interrupts share one pair.
		else if (mi_take)
		begin
			maskable_save_pc <= next_pc_in[`CSRF_PC_MSB:0];
			maskable_save_status <= program_status_word;
			exception_cause <= cause_code;
		end
		// Only writable numbers reach this case; the status word has its own process.
		else if (ld_ok)
		begin
			case (ld_num)
			`CSRF_NUM_MSAVE_PC: maskable_save_pc <= ld_data[`CSRF_PC_MSB:0];
			`CSRF_NUM_MSAVE_ST: maskable_save_status <= ld_data[`CSRF_ST_MSB:0];
			`CSRF_NUM_NSAVE_PC: nmi_save_pc <= ld_data[`CSRF_PC_MSB:0];
			`CSRF_NUM_NSAVE_ST: nmi_save_status <= ld_data[`CSRF_ST_MSB:0];
			`CSRF_NUM_TC_BASE: table_call_base <= ld_data;
			default: ;
			endcase
		end
	end
end

// ==========================================================================
// Status word
// Kept in a process of its own: events never touch it here, and a software
// load beats the sequencer's own flag update in the same cycle.
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
		program_status_word <= `CSRF_RST_PSW;
	else if (ld_ok && (ld_num == `CSRF_NUM_PSW))
		program_status_word <= ld_data[`CSRF_ST_MSB:0];
	else if (psw_upd)
		program_status_word <= psw_in[`CSRF_ST_MSB:0];
end

// ==========================================================================
// Store read path
// Storage reads take a cycle, so every read answers one cycle later for uniformity.
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		st_num_q <= {`CSRF_NUM_W{1'b0}};
		st_ready <= 1'b0;
	end
	else
	begin
		st_num_q <= st_num;
		st_ready <= st_valid;
	end
end

// Word returned for the registered store number; all registers read 32 bits wide.
always @*
begin
	st_data = `CSRF_RST_WORD;
	if (in_store(st_num_q))
		st_data = store_rd;
	else
	begin
		case (st_num_q)
		// Save PC reads keep bit 0 as written; only the return path clears it.
		`CSRF_NUM_MSAVE_PC: st_data = pc_word(maskable_save_pc);
		`CSRF_NUM_MSAVE_ST: st_data = st_word(maskable_save_status);
		`CSRF_NUM_NSAVE_PC: st_data = pc_word(nmi_save_pc);
		`CSRF_NUM_NSAVE_ST: st_data = st_word(nmi_save_status);
		`CSRF_NUM_CAUSE: st_data = exception_cause;
		`CSRF_NUM_PSW: st_data = program_status_word_out;
		`CSRF_NUM_TC_BASE: st_data = table_call_base;
		`CSRF_NUM_DEBUG: st_data = debug_in;
		default: st_data = `CSRF_RST_WORD;
		endcase
	end
end

// ==========================================================================
// Return values
// Bit 0 of the saved PC is dropped so the restored PC is always even.
always @*
begin
	ret_pc = `CSRF_RST_WORD;
	ret_status = `CSRF_RST_WORD;
	if (ret_nmi)
	begin
		ret_pc = pc_fmt(pc_word(nmi_save_pc));
		ret_status = st_word(nmi_save_status);
	end
	else if (ret_maskable)
	begin
		ret_pc = pc_fmt(pc_word(maskable_save_pc));
		ret_status = st_word(maskable_save_status);
	end
	// The table call return reads storage, so the sequencer must have put
	// the table call save number on the store port one cycle earlier.
	else if (ret_table_call)
	begin
		ret_pc = pc_fmt(store_rd);
		ret_status = `CSRF_RST_WORD;
	end
end

endmodule

// [bench/csrf_chk.sv]
// Purpose: Concurrent checks on the system register file ports.
// Assumes: Bound to csrf_top; a single clock domain.
// Notes: Judges only what the register file drives.
`timescale 1ns/10ps
module csrf_chk
#(
	parameter CAUSE_W = 32
)
(
	input logic sys_clk,
	input logic rst,
	input logic ld_valid,
	input logic [4:0] ld_num,
	input logic [31:0] ld_data,
	input logic st_valid,
	input logic [4:0] st_num,
	input logic [31:0] st_data,
	input logic st_ready,
	input logic mi_take,
	input logic nmi_take,
	input logic [31:0] next_pc_in,
	input logic [CAUSE_W-1:0] cause_code,
	input logic ret_maskable,
	input logic ret_nmi,
	input logic [31:0] ret_pc,
	input logic [31:0] program_status_word_out,
	input logic int_block
);
	// ==========================================================
	// Clocking
	// Everything sleeps through reset, so stale history never fires.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Sequences
	// An event, then a read of the cause register two cycles on.
	sequence s_evt_cause;
		(mi_take || nmi_take) ##2 (st_valid && st_num == 5'h04);
	endsequence
	// A maskable event followed by a return request.
	sequence s_mi_ret;
		(mi_take && !nmi_take) ##1 ret_maskable;
	endsequence
	// ==========================================================
	// Properties
	a_store_answer: assert property (st_valid |=> st_ready)
		else $error("store read not answered");
	a_cause_read: assert property (s_evt_cause |=> st_data == $past(cause_code, 3))
		else $error("cause register lost the event code");
	a_mi_save_pc: assert property (s_mi_ret |-> ret_pc == ($past(next_pc_in) & 32'h03FFFFFE))
		else $error("maskable save address wrong");
	a_ret_pc_even: assert property ((ret_maskable || ret_nmi) |-> (ret_pc & 32'hFC000001) == 32'h0)
		else $error("return address odd or too wide");
	a_psw_pad: assert property (program_status_word_out[31:8] == 24'h000000)
		else $error("status word upper bits set");
	a_psw_load: assert property ((ld_valid && ld_num == 5'h05)
		|=> program_status_word_out == ($past(ld_data) & 32'h000000FF))
		else $error("status word load not seen next cycle");
	a_id_early: assert property ((ld_valid && ld_num == 5'h05 && ld_data[5]) |-> int_block)
		else $error("interrupts not blocked during the load");
	a_id_flag: assert property (!ld_valid |-> int_block == program_status_word_out[5])
		else $error("blocking disagrees with the flag");
endmodule
bind csrf_top csrf_chk #(.CAUSE_W(CAUSE_W)) i_chk (.*);

// [bench/csrf_seq.sv]
// Purpose: Stand-in for the exception sequencer that raises events.
// Assumes: Each event is a one-cycle pulse launched at the falling edge.
// Notes: Idle address and code lines carry inverted junk, not the last value.
`timescale 1ns/10ps
module csrf_seq
(
	input wire sys_clk,
	output logic mi_take,
	output logic nmi_take,
	output logic [31:0] next_pc_in,
	output logic [31:0] cause_code
);
	// ==========================================================
	// Event launch
	// Quiet at time zero so no stray event is taken.
	initial
	begin
		mi_take = 1'b0;
		nmi_take = 1'b0;
		next_pc_in = 32'h0;
		cause_code = 32'h0;
	end
	// One event; pc is the address after the interrupted instruction.
	task fire(input logic mi, input logic nmi, input logic [31:0] pc, input logic [31:0] code);
	begin
		@(negedge sys_clk);
		mi_take = mi;
		nmi_take = nmi;
		next_pc_in = pc;
		cause_code = code;
		@(negedge sys_clk);
		mi_take = 1'b0;
		nmi_take = 1'b0;
		next_pc_in = ~pc;
		cause_code = ~code;
	end
	endtask
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the system register file.
// Assumes: Inputs change at the falling edge; store data read one cycle on.
// Notes: Sequencer flag updates are driven only in t_flags, table call returns only in t_plain.
`timescale 1ns/10ps
module testbench;
	logic sys_clk, rst, ld_valid, st_valid, st_ready, ret_maskable, ret_nmi, int_block;
	logic mi_take, nmi_take;
	logic [4:0] ld_num, st_num;
	logic [31:0] ld_data, st_data, ret_pc, ret_status, program_status_word_out;
	logic [31:0] next_pc_in, cause_code;
	logic ret_table_call, psw_upd, table_call_base_out;
	logic [31:0] psw_in, table_call_base_word;
	localparam logic [31:0] dbg_word = 32'h5A3C96E1;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// ==========================================================
	// Instances
	csrf_top i_dut (.*, .debug_in(dbg_word));
	csrf_seq i_seq (.sys_clk(sys_clk), .mi_take(mi_take), .nmi_take(nmi_take),
		.next_pc_in(next_pc_in), .cause_code(cause_code));
	// Free running clock and a hang guard well past the run length.
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_errors++;
			wrap_up;
		end
	end
	// ==========================================================
	// Shared tasks
	task chk(input logic [32:0] seen, input logic [32:0] exp);
	begin
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// Load: one strobe cycle, then the data lines scrambled.
	// Callers never pass the reserved numbers 6-15 or 22-31.
	task ld(input logic [4:0] num, input logic [31:0] data);
	begin
		@(negedge sys_clk);
		ld_valid = 1'b1;
		ld_num = num;
		ld_data = data;
		@(negedge sys_clk);
		ld_valid = 1'b0;
		ld_data = ~data;
	end
	endtask
	// Store read: the answer must stand one cycle after the request.
	task rd(input logic [4:0] num, input logic [31:0] exp);
	begin
		@(negedge sys_clk);
		st_valid = 1'b1;
		st_num = num;
		@(negedge sys_clk);
		st_valid = 1'b0;
		chk({st_ready, st_data}, {1'b1, exp});
	end
	endtask
	task wrap_up;
	begin
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// ==========================================================
	// Scenarios
	task t_walk;
	begin
		rd(5'h05, 32'h20);
		ld(5'h00, 32'h04000003);
		rd(5'h00, 32'h3);
		ret_maskable = 1'b1;
		#1 chk({1'b0, ret_pc}, 33'h2);
	end
	endtask
	// Writes to read-only numbers must leave no trace.
	task t_readonly;
	begin
		ld(5'h04, 32'hFFFFFFFF);
		ld(5'h15, 32'hFFFFFFFF);
		rd(5'h04, 32'h0);
		rd(5'h15, dbg_word);
		rd(5'h05, 32'h20);
	end
	endtask
	task t_plain;
	begin
		for (int i = 16; i <= 20; i++)
			ld(i[4:0], 32'h13579BDE ^ i);
		for (int i = 16; i <= 20; i++)
			rd(i[4:0], 32'h13579BDE ^ i);
		chk({table_call_base_out, table_call_base_word}, {1'b1, 32'h13579BCA});
		// Table call return: the save number stands a cycle before the select.
		@(negedge sys_clk);
		st_num = 5'h10;
		@(negedge sys_clk);
		ret_maskable = 1'b0;
		ret_table_call = 1'b1;
		#1 chk({1'b0, ret_pc}, 33'h03579BCE);
		chk({1'b0, ret_status}, 33'h0);
		ret_table_call = 1'b0;
		ret_maskable = 1'b1;
	end
	endtask
	task t_events;
	begin
		i_seq.fire(1'b1, 1'b0, 32'hFC001235, 32'hA0);
		rd(5'h04, 32'hA0);
		// Software reads out the maskable pair before another event may nest.
		rd(5'h00, 32'h1235);
		rd(5'h01, 32'h20);
		i_seq.fire(1'b0, 1'b1, 32'h00002000, 32'h10);
		rd(5'h04, 32'h10);
		rd(5'h00, 32'h1235);
		rd(5'h02, 32'h2000);
		rd(5'h03, 32'h20);
		ret_maskable = 1'b0;
		ret_nmi = 1'b1;
		#1 chk({1'b0, ret_pc}, 33'h2000);
		chk({1'b0, ret_status}, 33'h20);
	end
	endtask
	// Sequencer flag update, then a load in the same cycle that must win.
	task t_flags;
	begin
		@(negedge sys_clk);
		psw_upd = 1'b1;
		psw_in = 32'hFFFFFF07;
		@(negedge sys_clk);
		chk({1'b0, program_status_word_out}, 33'h07);
		ld(5'h05, 32'h00000020);
		psw_upd = 1'b0;
		chk({1'b0, program_status_word_out}, 33'h20);
	end
	endtask
	// A reset in mid-run brings back the reset values.
	task t_reset;
	begin
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		rd(5'h04, 32'h0);
		rd(5'h05, 32'h20);
		rd(5'h10, 32'h0);
	end
	endtask
	// The flag blocks already in the loading cycle.
	task t_psw;
	begin
		ld(5'h05, 32'hFFFFFFDF);
		chk({32'h0, int_block}, 33'h0);
		@(negedge sys_clk);
		ld_valid = 1'b1;
		ld_num = 5'h05;
		ld_data = 32'hFFFFFFFF;
		#1 chk({32'h0, int_block}, 33'h1);
		@(negedge sys_clk);
		ld_valid = 1'b0;
		chk({1'b0, program_status_word_out}, 33'hFF);
	end
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		rst = 1'b1;
		ld_valid = 1'b0;
		ld_num = 5'h00;
		ld_data = 32'h0;
		st_valid = 1'b0;
		st_num = 5'h00;
		ret_maskable = 1'b0;
		ret_nmi = 1'b0;
		ret_table_call = 1'b0;
		psw_upd = 1'b0;
		psw_in = 32'h0;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		t_walk;
		t_readonly;
		t_plain;
		t_events;
		t_psw;
		t_flags;
		t_reset;
		wrap_up;
	end
endmodule
